// ---- design/pcd_command_decoder.sv ----
// Management command decoder of the power supply, fed byte by byte from the bus engine.
//
// Functional notes
// - Write frame: command code, zero to three data bytes, then error-check byte.
// - Error-check byte over address and data is required on every command.
// - Multi-byte values travel low byte first, then high byte.
// - Values use direct format with slope, offset, exponent; swapped for input volts, fan.
// - Output voltage code is real volts times 400.
// - Output current readings use slope 5.
// - Input volts use offset 75; temperature, input power, fan percent slope 1.
// - Fan speed in rpm is scaled with slope 100.
// - Output defaults on after power-up while enable input is low.
// - On/off command: one byte, 0x80 on, 0x00 off.
// - Output restart clears latched alarms and shutdown conditions.
// - Fault-clear command resets isolation, restarted, invalid and error-check flags.
// - Output voltage command sets set point, limited to 42 to 58 volts.
// - Bus-programmed set point overrides margin input until power is removed.
// - Overvoltage limit command sets the shutdown threshold.
// - Combined status read returns a count byte, then nine bytes of status, alarms, telemetry.
// - D6 and D7 permit and forbid non-volatile memory writes.
// - D8 latches off after failure; D9 selects hiccup restart.
// - DA starts an isolation test.
// - DC, DD, DE return input, firmware revision and run-time data.
// - DF sets fan speed, E0 releases it, E1 reads fan, E2 test.
// - Unsupported command sets invalid-instruction flag and asserts alert.
// - Out-of-range data sets data flag and asserts alert.
// - Error-check mismatch sets its flag; command is not executed.
`timescale 1ns/1ps
`include "pcd_command_map.svh"

module pcd_command_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frmStart,
  input wire logic frmStop,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic txReq,
  output logic [7:0] txByte,
  input wire logic enablePin,
  input wire logic [15:0] marginCode,
  input wire logic [15:0] voutCodeMeas,
  input wire logic [12:0] ioutAmps,
  input wire logic [7:0] tempDegC,
  input wire logic [8:0] vinVolts,
  input wire logic [7:0] pinUnits,
  input wire logic [7:0] fanPct,
  input wire logic [15:0] fanRpm,
  input wire logic [7:0] alarm2,
  input wire logic [7:0] alarm1,
  input wire logic powerCapHigh,
  input wire logic internalFault,
  input wire logic externalFault,
  input wire logic shutdownState,
  input wire logic [23:0] fwRev,
  input wire logic [23:0] runTimer,
  input wire logic isoDone,
  input wire logic isoOk,
  input wire logic stateChange,
  output logic outputOn,
  output logic restartPulse,
  output logic [15:0] vsetCode,
  output logic vsetProgrammed,
  output logic [15:0] ovLimitCode,
  output logic lampTest,
  output logic serviceLamp,
  output logic nvWriteEn,
  output logic latchOff,
  output logic isoStart,
  output logic fanOverride,
  output logic [23:0] fanSetting,
  output logic productionClockHold,
  output logic alertN,
  output logic commErr,
  output logic [7:0] status2,
  output logic [7:0] status1
);

  // ******************************************************************
  // Command tables
  // ******************************************************************
  function automatic pcd_pkg::pcd_len_t wrLen(input logic [7:0] code);
    pcd_pkg::pcd_len_t r;
    r = '{known: 1'b1, len: 4'h0};
    unique case (code)
      `PCD_CMD_OPERATION: r.len = `PCD_LEN_OPERATION;
      `PCD_CMD_VOUT, `PCD_CMD_OV_LIMIT: r.len = `PCD_LEN_WORD;
      `PCD_CMD_FAN_SET: r.len = `PCD_LEN_FAN_SET;
      `PCD_CMD_CLEAR, `PCD_CMD_LAMP_TEST_START, `PCD_CMD_LAMP_TEST_STOP,
      `PCD_CMD_SERVICE_LAMP_SET, `PCD_CMD_SERVICE_LAMP_CLEAR, `PCD_CMD_NV_WRITE_ON,
      `PCD_CMD_NV_WRITE_OFF, `PCD_CMD_LATCH_OFF, `PCD_CMD_AUTO_RESTART,
      `PCD_CMD_ISO_TEST, `PCD_CMD_FAN_NORMAL, `PCD_CMD_PRODUCTION_CLOCK_HOLD: r.len = 4'h0;
      default: r.known = 1'b0;
    endcase
    return r;
  endfunction

  function automatic pcd_pkg::pcd_len_t rdLen(input logic [7:0] code);
    pcd_pkg::pcd_len_t r;
    r = '{known: 1'b1, len: 4'h0};
    unique case (code)
      `PCD_CMD_READ_STATUS: r.len = `PCD_LEN_READ_STATUS;
      `PCD_CMD_READ_INPUT: r.len = `PCD_LEN_READ_INPUT;
      `PCD_CMD_READ_FW_REV: r.len = `PCD_LEN_READ_FW_REV;
      `PCD_CMD_READ_RUN_TIMER: r.len = `PCD_LEN_READ_RUN_TIMER;
      `PCD_CMD_READ_FAN: r.len = `PCD_LEN_READ_FAN;
      default: r.known = 1'b0;
    endcase
    return r;
  endfunction

  // ******************************************************************
  // Pin synchroniser and frame tracking
  // ******************************************************************
  logic enMeta_reg;
  logic enSync_reg;
  pcd_pkg::pcd_state_t state_reg;
  logic [2:0] rxCount_reg;
  logic [7:0] rxBuf [0:4];
  logic [7:0] pecPrev_reg;
  logic [3:0] txIdx_reg;
  logic [7:0] crc;
  logic [7:0] txNext;
  logic txLoad;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enMeta_reg <= 1'b1;
      enSync_reg <= 1'b1;
    end else begin
      enMeta_reg <= enablePin;
      enSync_reg <= enMeta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || frmStop) begin
      state_reg <= pcd_pkg::PCD_IDLE;
    end else if (frmStart) begin
      state_reg <= pcd_pkg::PCD_ADDR;
    end else if (rxValid && state_reg == pcd_pkg::PCD_ADDR) begin
      if (!rxByte[0]) begin
        state_reg <= pcd_pkg::PCD_WRITE;
      end else if (rxCount_reg != 3'h0) begin
        state_reg <= pcd_pkg::PCD_READ;
      end else begin
        state_reg <= pcd_pkg::PCD_SKIP;
      end
    end
  end

  // The byte count survives a repeated start so a read knows its command.
  always_ff @(posedge clk) begin
    if (!rst_n || (frmStart && state_reg == pcd_pkg::PCD_IDLE)) begin
      rxCount_reg <= 3'h0;
      pecPrev_reg <= `PCD_PEC_INIT;
    end else if (rxValid && state_reg == pcd_pkg::PCD_WRITE) begin
      if (rxCount_reg < `PCD_MAX_FRAME_BYTES) begin
        rxBuf[rxCount_reg] <= rxByte;
      end
      if (rxCount_reg != 3'h7) begin
        rxCount_reg <= rxCount_reg + 3'h1;
      end
      pecPrev_reg <= crc;
    end
  end

  assign txLoad = txReq && state_reg == pcd_pkg::PCD_READ;

  pcd_pec_unit pecUnit (
    .clk(clk),
    .rst_n(rst_n),
    .clear(frmStart && state_reg == pcd_pkg::PCD_IDLE),
    .update((rxValid && (state_reg == pcd_pkg::PCD_ADDR || state_reg == pcd_pkg::PCD_WRITE))
            || txLoad),
    .dataIn(txLoad ? txNext : rxByte),
    .crc(crc)
  );

  // ******************************************************************
  // Write decode
  // ******************************************************************
  logic [7:0] cmd;
  logic [2:0] dataN;
  logic [15:0] word;
  logic exec;
  logic runCmd;
  logic setPec;
  logic setInv;
  logic setData;
  logic setComm;
  logic doClear;
  pcd_pkg::pcd_len_t wl;

  assign cmd = rxBuf[0];
  assign dataN = rxCount_reg - 3'h2;
  assign word = {rxBuf[2], rxBuf[1]};
  assign exec = frmStop && state_reg == pcd_pkg::PCD_WRITE && rxCount_reg != 3'h0;
  assign wl = wrLen(cmd);

  always_comb begin
    runCmd = 1'b0;
    setPec = 1'b0;
    setInv = 1'b0;
    setComm = 1'b0;
    if (exec) begin
      if (rxCount_reg < 3'h2 || rxCount_reg > `PCD_MAX_FRAME_BYTES) begin
        setComm = 1'b1;
      end else if (pecPrev_reg != rxBuf[rxCount_reg - 3'h1]) begin
        setPec = 1'b1;
      end else if (!wl.known) begin
        if (rdLen(cmd).known) begin
          setComm = 1'b1;
        end else begin
          setInv = 1'b1;
        end
      end else if ({1'b0, dataN} != wl.len) begin
        setComm = 1'b1;
      end else begin
        runCmd = 1'b1;
      end
    end
  end

  always_comb begin
    setData = 1'b0;
    doClear = runCmd && cmd == `PCD_CMD_CLEAR;
    if (runCmd && cmd == `PCD_CMD_OPERATION) begin
      setData = rxBuf[1] != `PCD_OP_ON && rxBuf[1] != `PCD_OP_OFF;
    end
    if (runCmd && cmd == `PCD_CMD_VOUT) begin
      setData = word < `PCD_VOUT_MIN_CODE || word > `PCD_VOUT_MAX_CODE;
    end
  end

  // ******************************************************************
  // Output control and restart
  // ******************************************************************
  logic opOn_reg;
  logic primed_reg;
  logic onNext;
  logic restartEv;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opOn_reg <= 1'b1;
    end else if (runCmd && cmd == `PCD_CMD_OPERATION && !setData) begin
      opOn_reg <= rxBuf[1] == `PCD_OP_ON;
    end
  end

  assign onNext = opOn_reg && !enSync_reg;
  assign restartEv = primed_reg && onNext && !outputOn;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outputOn <= 1'b0;
      primed_reg <= 1'b0;
      restartPulse <= 1'b0;
    end else begin
      outputOn <= onNext;
      primed_reg <= primed_reg || outputOn;
      restartPulse <= restartEv;
    end
  end

  // ******************************************************************
  // Set point, limit and settings
  // ******************************************************************
  logic [15:0] vsetProg_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vsetProg_reg <= 16'h0000;
      vsetProgrammed <= 1'b0;
      vsetCode <= 16'h0000;
    end else begin
      if (runCmd && cmd == `PCD_CMD_VOUT && !setData) begin
        vsetProg_reg <= word;
        vsetProgrammed <= 1'b1;
      end
      vsetCode <= vsetProgrammed ? vsetProg_reg : marginCode;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovLimitCode <= `PCD_OV_LIMIT_RST;
    end else if (runCmd && cmd == `PCD_CMD_OV_LIMIT) begin
      ovLimitCode <= word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lampTest <= 1'b0;
      serviceLamp <= 1'b0;
      nvWriteEn <= 1'b0;
      latchOff <= 1'b0;
      isoStart <= 1'b0;
      productionClockHold <= 1'b0;
    end else begin
      isoStart <= runCmd && cmd == `PCD_CMD_ISO_TEST;
      productionClockHold <= runCmd && cmd == `PCD_CMD_PRODUCTION_CLOCK_HOLD;
      if (runCmd) begin
        unique case (cmd)
          `PCD_CMD_LAMP_TEST_START: lampTest <= 1'b1;
          `PCD_CMD_LAMP_TEST_STOP: lampTest <= 1'b0;
          `PCD_CMD_SERVICE_LAMP_SET: serviceLamp <= 1'b1;
          `PCD_CMD_SERVICE_LAMP_CLEAR: serviceLamp <= 1'b0;
          `PCD_CMD_NV_WRITE_ON: nvWriteEn <= 1'b1;
          `PCD_CMD_NV_WRITE_OFF: nvWriteEn <= 1'b0;
          `PCD_CMD_LATCH_OFF: latchOff <= 1'b1;
          `PCD_CMD_AUTO_RESTART: latchOff <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fanOverride <= 1'b0;
      fanSetting <= 24'h000000;
    end else if (runCmd && cmd == `PCD_CMD_FAN_SET) begin
      fanOverride <= 1'b1;
      fanSetting <= {rxBuf[3], rxBuf[2], rxBuf[1]};
    end else if (runCmd && cmd == `PCD_CMD_FAN_NORMAL) begin
      fanOverride <= 1'b0;
    end
  end

  // ******************************************************************
  // Status flags and alert; a set in the same cycle beats a clear
  // ******************************************************************
  logic pecErr_reg;
  logic invCmd_reg;
  logic invData_reg;
  logic restarted_reg;
  logic isoPass_reg;
  logic isoFail_reg;
  logic alert_reg;
  logic badRead;
  logic statusDone;
  logic flagClr;

  assign flagClr = doClear || restartEv;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pecErr_reg <= 1'b0;
      invCmd_reg <= 1'b0;
      invData_reg <= 1'b0;
      commErr <= 1'b0;
      restarted_reg <= 1'b0;
      isoPass_reg <= 1'b0;
      isoFail_reg <= 1'b0;
    end else begin
      pecErr_reg <= setPec || (pecErr_reg && !flagClr);
      invCmd_reg <= setInv || badRead || (invCmd_reg && !flagClr);
      invData_reg <= setData || (invData_reg && !flagClr);
      commErr <= setComm || (commErr && !flagClr);
      restarted_reg <= restartEv || (restarted_reg && !doClear);
      isoPass_reg <= (isoDone && isoOk) || (isoPass_reg && !doClear);
      isoFail_reg <= (isoDone && !isoOk) || (isoFail_reg && !doClear);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_reg <= 1'b0;
      alertN <= 1'b1;
    end else begin
      if (setPec || setInv || badRead || setData || setComm || stateChange) begin
        alert_reg <= 1'b1;
      end else if (flagClr || statusDone) begin
        alert_reg <= 1'b0;
      end
      alertN <= !alert_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status2 <= 8'h00;
      status1 <= 8'h00;
    end else begin
      status2 <= {pecErr_reg, !latchOff, invCmd_reg, powerCapHigh,
                  isoFail_reg, restarted_reg, invData_reg, enSync_reg};
      status1 <= {1'b0, isoPass_reg, internalFault, shutdownState,
                  serviceLamp, externalFault, lampTest, outputOn};
    end
  end

  // ******************************************************************
  // Read data
  // ******************************************************************
  pcd_pkg::pcd_len_t rl;
  logic block;
  logic [3:0] total;
  logic [3:0] dataIdx;
  logic [71:0] readVec;
  logic [15:0] ioutCode;
  logic [7:0] vinCode;
  logic [15:0] rpmCode;

  assign rl = rdLen(cmd);
  assign block = rl.len > `PCD_LEN_PLAIN_MAX;
  assign total = rl.len + {3'h0, block};
  assign dataIdx = txIdx_reg - {3'h0, block};
  assign ioutCode = 16'(ioutAmps * `PCD_IOUT_M);
  assign vinCode = (vinVolts < 9'(`PCD_VIN_B)) ? 8'h00 : 8'(vinVolts - 9'(`PCD_VIN_B));
  assign rpmCode = 16'(fanRpm / `PCD_RPM_M);
  assign badRead = txLoad && txIdx_reg == 4'h0 && !rl.known;
  assign statusDone = txLoad && txIdx_reg == total && cmd == `PCD_CMD_READ_STATUS;

  always_comb begin
    readVec = 72'h0;
    unique case (cmd)
      `PCD_CMD_READ_STATUS: readVec = {tempDegC, ioutCode, voutCodeMeas,
                                       alarm1, alarm2, status1, status2};
      `PCD_CMD_READ_INPUT: readVec = {56'h0, pinUnits, vinCode};
      `PCD_CMD_READ_FW_REV: readVec = {48'h0, fwRev};
      `PCD_CMD_READ_RUN_TIMER: readVec = {48'h0, runTimer};
      `PCD_CMD_READ_FAN: readVec = {40'h0, rpmCode, fanPct, 7'h00, fanOverride};
      default: readVec = 72'h0;
    endcase
  end

  always_comb begin
    if (!rl.known || txIdx_reg > total) begin
      txNext = `PCD_IDLE_BYTE;
    end else if (txIdx_reg == total) begin
      txNext = crc;
    end else if (block && txIdx_reg == 4'h0) begin
      txNext = {4'h0, rl.len};
    end else begin
      txNext = readVec[{dataIdx, 3'h0} +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txIdx_reg <= 4'h0;
      txByte <= `PCD_IDLE_BYTE;
    end else if (state_reg != pcd_pkg::PCD_READ) begin
      txIdx_reg <= 4'h0;
    end else if (txLoad) begin
      txByte <= txNext;
      if (txIdx_reg != 4'hF) begin
        txIdx_reg <= txIdx_reg + 4'h1;
      end
    end
  end

endmodule // pcd_command_decoder

// ---- design/pcd_command_map.svh ----
// Command codes, lengths, scaling constants and reset values of the command decoder.
`ifndef PCD_COMMAND_MAP_SVH
`define PCD_COMMAND_MAP_SVH

`define PCD_CMD_OPERATION 8'h01
`define PCD_CMD_CLEAR 8'h03
`define PCD_CMD_VOUT 8'h21
`define PCD_CMD_OV_LIMIT 8'h40
`define PCD_CMD_READ_STATUS 8'hD0
`define PCD_CMD_LAMP_TEST_START 8'hD2
`define PCD_CMD_LAMP_TEST_STOP 8'hD3
`define PCD_CMD_SERVICE_LAMP_SET 8'hD4
`define PCD_CMD_SERVICE_LAMP_CLEAR 8'hD5
`define PCD_CMD_NV_WRITE_ON 8'hD6
`define PCD_CMD_NV_WRITE_OFF 8'hD7
`define PCD_CMD_LATCH_OFF 8'hD8
`define PCD_CMD_AUTO_RESTART 8'hD9
`define PCD_CMD_ISO_TEST 8'hDA
`define PCD_CMD_READ_INPUT 8'hDC
`define PCD_CMD_READ_FW_REV 8'hDD
`define PCD_CMD_READ_RUN_TIMER 8'hDE
`define PCD_CMD_FAN_SET 8'hDF
`define PCD_CMD_FAN_NORMAL 8'hE0
`define PCD_CMD_READ_FAN 8'hE1
`define PCD_CMD_PRODUCTION_CLOCK_HOLD 8'hE2

`define PCD_LEN_OPERATION 4'h1
`define PCD_LEN_WORD 4'h2
`define PCD_LEN_FAN_SET 4'h3
`define PCD_LEN_READ_STATUS 4'h9
`define PCD_LEN_READ_INPUT 4'h2
`define PCD_LEN_READ_FW_REV 4'h3
`define PCD_LEN_READ_RUN_TIMER 4'h3
`define PCD_LEN_READ_FAN 4'h4
`define PCD_LEN_PLAIN_MAX 4'h2
`define PCD_MAX_FRAME_BYTES 3'h5

`define PCD_OP_ON 8'h80
`define PCD_OP_OFF 8'h00

`define PCD_VOUT_M 400
`define PCD_VOUT_MIN_V 42
`define PCD_VOUT_MAX_V 58
`define PCD_VOUT_MIN_CODE 16'(`PCD_VOUT_MIN_V * `PCD_VOUT_M)
`define PCD_VOUT_MAX_CODE 16'(`PCD_VOUT_MAX_V * `PCD_VOUT_M)
`define PCD_IOUT_M 5
`define PCD_VIN_B 75
`define PCD_RPM_M 100

`define PCD_PEC_POLY 8'h07
`define PCD_PEC_INIT 8'h00
`define PCD_OV_LIMIT_RST 16'h5DC0
`define PCD_IDLE_BYTE 8'hFF

`endif

// ---- design/pcd_pkg.sv ----
// Types shared by the command decoder files.
package pcd_pkg;

  typedef enum logic [4:0] {
    PCD_IDLE  = 5'h01,
    PCD_ADDR  = 5'h02,
    PCD_WRITE = 5'h04,
    PCD_READ  = 5'h08,
    PCD_SKIP  = 5'h10
  } pcd_state_t;

  typedef struct packed {
    logic known;
    logic [3:0] len;
  } pcd_len_t;

endpackage

// ---- design/pcd_pec_unit.sv ----
// Running packet error code over the bytes of one frame.
`timescale 1ns/1ps
`include "pcd_command_map.svh"

module pcd_pec_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic update,
  input wire logic [7:0] dataIn,
  output logic [7:0] crc
);

  logic [7:0] crcNext;

  always_comb begin
    crcNext = crc ^ dataIn;
    for (int i = 0; i < 8; i++) begin
      crcNext = crcNext[7] ? ((crcNext << 1) ^ `PCD_PEC_POLY) : (crcNext << 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      crc <= `PCD_PEC_INIT;
    end else if (update) begin
      crc <= crcNext;
    end
  end

endmodule // pcd_pec_unit

// ---- sim/pcd_decoder_monitor.sv ----
// Temporal checks on the command decoder's ports.
`timescale 1ns/1ps
module pcd_decoder_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enablePin,
  input wire logic outputOn,
  input wire logic restartPulse,
  input wire logic [15:0] vsetCode,
  input wire logic vsetProgrammed,
  input wire logic [15:0] ovLimitCode,
  input wire logic isoStart,
  input wire logic alertN,
  input wire logic [7:0] status2
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_RESTART_FLAGS: assert property (restartPulse |-> ##[0:2] (status2[2] && !status2[7]))
    else $error("restart left flags wrong");
  AST_RESTART_ON: assert property (restartPulse |-> ##[0:1] outputOn)
    else $error("restart without output on");
  AST_PROG_STICKY: assert property (vsetProgrammed |=> vsetProgrammed)
    else $error("programmed set point lost");
  AST_PROG_RANGE: assert property (vsetProgrammed && $past(vsetProgrammed) |->
    (vsetCode >= 16'd16800 && vsetCode <= 16'd23200))
    else $error("set point out of range");
  AST_INVDATA_ALERT: assert property ($rose(status2[1]) |-> ##[0:1] !alertN)
    else $error("bad data without alert");
  AST_INVCMD_ALERT: assert property ($rose(status2[5]) |-> ##[0:1] !alertN)
    else $error("bad command without alert");
  AST_PEC_ALERT: assert property ($rose(status2[7]) |-> ##[0:1] !alertN)
    else $error("check byte error without alert");
  AST_PEC_NO_EXEC: assert property ($rose(status2[7]) |-> $past(ovLimitCode) == $past(ovLimitCode, 2))
    else $error("command executed despite bad check byte");
  AST_ISO_PULSE: assert property (isoStart |=> !isoStart)
    else $error("isolation start longer than one cycle");
  AST_ENABLE_OFF: assert property (enablePin [*5] |-> !outputOn)
    else $error("output on while enable pin high");
endmodule // pcd_decoder_monitor

bind pcd_command_decoder pcd_decoder_monitor i_mon (
  .clk, .rst_n, .enablePin, .outputOn, .restartPulse, .vsetCode, .vsetProgrammed,
  .ovLimitCode, .isoStart, .alertN, .status2
);

// ---- sim/pcd_host_model.sv ----
// Host controller model that frames commands on the decoder's byte interface.
`timescale 1ns/1ps
module pcd_host_model (
  input wire logic clk,
  output logic frmStart,
  output logic frmStop,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic txReq
);
  logic [7:0] pec = 8'h00;
  initial begin
    {frmStart, frmStop, rxValid, txReq, rxByte} = 12'h0A5;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    end
    return x;
  endfunction
  // One event per two cycles; the released byte lane shows the inverse value.
  task automatic hit(input logic [3:0] m, input logic [7:0] b);
    {frmStart, frmStop, rxValid, txReq} <= m;
    rxByte <= b;
    if (m[1]) begin
      pec = crc8(pec, b);
    end
    @(posedge clk);
    {frmStart, frmStop, rxValid, txReq} <= 4'h0;
    rxByte <= ~b;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int n, input bit bad);
    @(posedge clk);
    pec = 8'h00;
    hit(4'h8, 8'h00);
    hit(4'h2, cmd == 8'h21 ? 8'h00 : 8'h8E);
    hit(4'h2, cmd);
    for (int i = 0; i < n; i++) begin
      hit(4'h2, d[8*i+:8]);
    end
    hit(4'h2, bad ? ~pec : pec);
    hit(4'h4, 8'h00);
  endtask
  task automatic rd(input logic [7:0] cmd, input int n);
    @(posedge clk);
    pec = 8'h00;
    hit(4'h8, 8'h00);
    hit(4'h2, 8'h8E);
    hit(4'h2, cmd);
    hit(4'h8, 8'h00);
    hit(4'h2, 8'h8F);
    repeat (n) hit(4'h1, 8'h00);
    hit(4'h4, 8'h00);
  endtask
endmodule // pcd_host_model

// ---- sim/tb_top.sv ----
// Self-checking bench of the command decoder driven by the host model.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enablePin = 1'b0;
  logic frmStart, frmStop, rxValid, txReq, reqSeen, powerCapHigh, internalFault;
  logic externalFault, shutdownState, isoDone, isoOk, stateChange, outputOn, restartPulse;
  logic vsetProgrammed, lampTest, serviceLamp, nvWriteEn, latchOff, isoStart, fanOverride;
  logic productionClockHold, alertN, commErr;
  logic [7:0] rxByte, txByte, tempDegC, pinUnits, fanPct, alarm2, alarm1, status2, status1;
  logic [15:0] marginCode, voutCodeMeas, fanRpm, vsetCode, ovLimitCode, v, io, rp;
  logic [12:0] ioutAmps;
  logic [8:0] vinVolts;
  logic [23:0] fwRev, runTimer, fanSetting, f;
  logic [3:0] lamps = 4'h0;
  logic [1:0] pulses = 2'h0;
  logic [7:0] expQ[$];
  int errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  pcd_host_model i_host (.clk, .frmStart, .frmStop, .rxValid, .rxByte, .txReq);
  pcd_command_decoder i_dut (
    .clk, .rst_n, .frmStart, .frmStop, .rxValid, .rxByte, .txReq, .txByte, .enablePin,
    .marginCode, .voutCodeMeas, .ioutAmps, .tempDegC, .vinVolts, .pinUnits, .fanPct, .fanRpm,
    .alarm2, .alarm1, .powerCapHigh, .internalFault, .externalFault, .shutdownState, .fwRev,
    .runTimer, .isoDone, .isoOk, .stateChange, .outputOn, .restartPulse, .vsetCode,
    .vsetProgrammed, .ovLimitCode, .lampTest, .serviceLamp, .nvWriteEn, .latchOff, .isoStart,
    .fanOverride, .fanSetting, .productionClockHold, .alertN, .commErr, .status2, .status1
  );

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rdChk(input logic [7:0] cmd, input logic [7:0] b[$]);
    logic [7:0] p;
    p = i_host.crc8(i_host.crc8(i_host.crc8(8'h00, 8'h8E), cmd), 8'h8F);
    foreach (b[i]) begin
      expQ.push_back(b[i]);
      p = i_host.crc8(p, b[i]);
    end
    expQ.push_back(p);
    i_host.rd(cmd, b.size() + 1);
    chk("pending", 24'h0, 24'(expQ.size()));
  endtask

  always @(posedge clk) begin
    reqSeen <= txReq;
    pulses <= pulses | {productionClockHold === 1'b1, isoStart === 1'b1};
  end
  always @(negedge clk) begin
    if (reqSeen === 1'b1) begin
      chk("txByte", expQ.size() > 0 ? expQ.pop_front() : 24'h1FF, txByte);
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("mismatch watchdog expected end seen hang");
    results();
  end

  initial begin
    {marginCode, voutCodeMeas, fanRpm, alarm2, alarm1, tempDegC, pinUnits, fanPct} = '0;
    {ioutAmps, vinVolts, powerCapHigh, internalFault, externalFault, shutdownState} = '0;
    {fwRev, runTimer, isoDone, isoOk, stateChange} = '0;
    void'($urandom(32'hD494));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    {voutCodeMeas, fanRpm, alarm2, alarm1, tempDegC, pinUnits} <= {$urandom, $urandom};
    {fanPct, marginCode, ioutAmps} <= 37'({$urandom, $urandom});
    vinVolts <= 9'(75 + $urandom_range(0, 255));
    {powerCapHigh, internalFault, externalFault, shutdownState} <= 4'($urandom);
    {fwRev, runTimer} <= {$urandom, 16'($urandom)};
    repeat (6) @(posedge clk);
    #1;
    chk("outputOn", 1, outputOn);
    chk("ovLimitCode", 16'h5DC0, ovLimitCode);
    chk("vsetCode", marginCode, vsetCode);
    $display("test powerup done");
    v = 16'($urandom_range(16800, 23200));
    i_host.wr(8'h21, 24'(v), 2, 1'b0);
    settle();
    chk("vsetCode", v, vsetCode);
    @(posedge clk) marginCode <= ~marginCode;
    settle();
    chk("vsetCode", v, vsetCode);
    i_host.wr(8'h21, 24'd23200, 2, 1'b0);
    i_host.wr(8'h21, 24'd23201, 2, 1'b0);
    settle();
    chk("vsetCode", 16'd23200, vsetCode);
    chk("invData", 1, status2[1]);
    $display("test vout done");
    i_host.wr(8'h40, 24'h5A00, 2, 1'b1);
    settle();
    chk("ovLimitCode", 16'h5DC0, ovLimitCode);
    chk("pecErr", 1, status2[7]);
    i_host.wr(8'h40, 24'h5A00, 2, 1'b0);
    i_host.wr(8'hC5, 24'h0, 0, 1'b0);
    i_host.wr(8'h01, 24'h0, 2, 1'b0);
    isoDone <= 1'b1;
    @(posedge clk) isoDone <= 1'b0;
    settle();
    chk("ovLimitCode", 16'h5A00, ovLimitCode);
    chk("invCmd", 1, status2[5]);
    chk("commErr", 1, commErr);
    chk("outputOn", 1, outputOn);
    chk("isoFail", 1, status2[3]);
    i_host.wr(8'h03, 24'h0, 0, 1'b0);
    settle();
    chk("flags", 0, status2 & 8'hAE);
    chk("alertN", 1, alertN);
    $display("test faults done");
    for (int i = 0; i < 8; i++) begin
      i_host.wr(8'hD2 + 8'(i), 24'h0, 0, 1'b0);
      lamps[i >> 1] = !i[0];
      settle();
      chk("lamps", lamps, {latchOff, nvWriteEn, serviceLamp, lampTest});
      chk("willRestart", !lamps[3], status2[6]);
    end
    i_host.wr(8'hDA, 24'h0, 0, 1'b0);
    i_host.wr(8'hE2, 24'h0, 0, 1'b0);
    f = 24'($urandom);
    i_host.wr(8'hDF, f, 3, 1'b0);
    settle();
    chk("fanSetting", f, fanSetting);
    chk("pulses", 2'h3, pulses);
    rp = fanRpm / 16'd100;
    rdChk(8'hE1, '{8'h04, 8'h01, fanPct, rp[7:0], rp[15:8]});
    i_host.wr(8'hE0, 24'h0, 0, 1'b0);
    settle();
    chk("fanOverride", 0, fanOverride);
    $display("test commands done");
    io = 16'(ioutAmps) * 16'd5;
    rdChk(8'hD0, '{8'h09, {3'b010, powerCapHigh, 4'h0},
      {2'b00, internalFault, shutdownState, 1'b0, externalFault, 2'b01}, alarm2, alarm1,
      voutCodeMeas[7:0], voutCodeMeas[15:8], io[7:0], io[15:8], tempDegC});
    rdChk(8'hDC, '{8'(vinVolts - 9'd75), pinUnits});
    rdChk(8'hDD, '{8'h03, fwRev[7:0], fwRev[15:8], fwRev[23:16]});
    rdChk(8'hDE, '{8'h03, runTimer[7:0], runTimer[15:8], runTimer[23:16]});
    $display("test reads done");
    i_host.wr(8'h01, 24'h00, 1, 1'b0);
    settle();
    chk("outputOn", 0, outputOn);
    chk("status1", 8'h00, status1 & 8'h4B);
    i_host.wr(8'h01, 24'h80, 1, 1'b0);
    settle();
    chk("outputOn", 1, outputOn);
    chk("restarted", 1, status2[2]);
    i_host.wr(8'h01, 24'h40, 1, 1'b0);
    settle();
    chk("invData", 1, status2[1]);
    @(posedge clk) enablePin <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("outputOn", 0, outputOn);
    $display("test operation done");
    results();
  end
endmodule // tb_top
